// >>> core/audio_serial_status_flags.sv
// Status word, flag sequencing and requests of the audio serial unit
`timescale 1ns/1ns
//
// Contract
// - Status word read-only, reserved bits zero
// - Flag zero needs bit clock pin input
// - Flag one needs frame pin input, no buffer
// - Flag two needs high clock pin input
// - Sample pin at first bit, copy on transfer
// - Frame start marks first slot words
// - Frame start valid with receivers; normal reads one
// - Overrun when transfer meets full holding
// - Overrun raises exception request when enabled
// - Overrun clears: status read, then all reads
// - Full sets on transfer, clears after reads
// - Full raises data request when enabled
// - Even full on even slot transfer
// - Even full clears on reads, raises request
// - Odd full on odd slot, clears on reads
// - Transmit frame start only in first slot
// - First slot writes go out in slot two
// - Transmit frame start valid; normal reads one
// - Underrun on empty slot, resend, request
// - Underrun clears: status read, then writes
// - Empty sets on load in an active slot
// - Empty clears on all writes or null
// - Every reset clears every status flag
// - Receive exception request outranks receive data requests
module audio_serial_status_flags
	import status_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Receiver pins: bit clock, frame sync, high clock
	input  wire logic [2:0]             rx_pins,
	// Datapath events
	input  status_pkg::rx_evt_t         rx_evt,
	input  status_pkg::tx_evt_t         tx_evt,
	// Software, unit and stop resets
	input  wire logic                   soft_reset,
	input  wire logic                   unit_reset,
	input  wire logic                   stop_reset,
	// Requests and datapath control
	output logic                        irq_rx_exc,
	output logic                        irq_rx,
	output logic                        irq_rx_even,
	output logic                        irq_tx,
	output logic                        irq_tx_exc,
	output logic                        tx_resend,
	output logic                        tx_pending_r
);
	import status_pkg::*;

	logic [31:0] ctrl_r;
	flags_t      st_r;
	logic [2:0]  pin_lvl;
	logic [2:0]  pin_smp_r;
	logic [3:0]  rx_mask_r;
	logic [5:0]  tx_mask_r;
	logic        roe_arm_r;
	logic        tue_arm_r;
	logic [31:0] rd_nxt;
	logic [23:0] status_word;
	logic [2:0]  flag_en;
	logic        clear_all;
	logic        hit_status;
	logic        hit_ctrl;
	logic        apb_done;
	logic        st_read;
	logic        rx_all_read;
	logic        tx_all_written;
	logic        net;
	logic [3:0]  rx_en;
	logic [5:0]  tx_en;
	logic        tx_short;

	// True when this event completes coverage of every enabled unit
	function automatic logic all_done(input logic [5:0] mask, input logic [5:0] hit,
		input logic [5:0] en);
		all_done = (en != 6'h00) && ((hit & en) != 6'h00) && (((mask | hit) & en) == en);
	endfunction

	function automatic logic idx_hit(input logic [31:0] addr, input logic [23:0] idx);
		idx_hit = (addr[1:0] == 2'b00) && (addr[31:26] == 6'h00) && (addr[25:2] == idx);
	endfunction

	// Pins arrive from another clock domain
	pin_sync #(
		.W(PIN_N)
	) u_pin_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (rx_pins),
		.level_out (pin_lvl)
	);

	assign net   = ctrl_r[C_NET];
	assign rx_en = ctrl_r[C_RXEN +: RX_N];
	assign tx_en = ctrl_r[C_TXEN +: TX_N];
	assign clear_all = soft_reset | unit_reset | stop_reset;

	// Input flag enables from pin assignment and direction
	assign flag_en[0] = ctrl_r[C_PIN] & ctrl_r[C_SYN] & ~ctrl_r[C_RX_CLOCK_DIRECTION];
	assign flag_en[1] = ctrl_r[C_PIN + 1] & ctrl_r[C_SYN] & ~ctrl_r[C_RX_FRAMESYNC_DIRECTION]
		& ~ctrl_r[C_TX_BUFFER_ENABLE_SELECT];
	assign flag_en[2] = ctrl_r[C_PIN + 2] & ctrl_r[C_SYN] & ~ctrl_r[C_RX_HIGHCLOCK_DIRECTION];

	// Reserved positions stay zero
	always_comb begin
		status_word = '0;
		status_word[B_IF0 +: 3] = st_r.in_flag & flag_en;
		status_word[B_RFS]  = st_r.receive_frame_start_flag;
		status_word[B_ROE]  = st_r.receive_overrun_flag;
		status_word[B_RDF]  = st_r.receive_full_flag;
		status_word[B_RECEIVE_EVEN_FULL_FLAG] = st_r.receive_even_full_flag;
		status_word[B_RECEIVE_ODD_FULL_FLAG] = st_r.receive_odd_full_flag;
		status_word[B_TFS]  = st_r.transmit_frame_start_flag;
		status_word[B_TUE]  = st_r.transmit_underrun_flag;
		status_word[B_TDE]  = st_r.transmit_empty_flag;
	end

	// APB: one registered wait answer per access
	assign hit_status = idx_hit(paddr, STATUS_IDX);
	assign hit_ctrl   = idx_hit(paddr, CTRL_IDX);
	assign apb_done   = psel & penable & pready;
	assign st_read    = apb_done & ~pwrite & hit_status;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit_status) begin
			rd_nxt = {8'h00, status_word};
		end else if (hit_ctrl) begin
			rd_nxt = ctrl_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
			// Writes to the status word are refused
			pslverr <= ~(hit_ctrl | (hit_status & ~pwrite));
		end else if (apb_done) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (apb_done & pwrite & hit_ctrl) begin
			ctrl_r <= pwdata;
		end
	end

	// Read and write coverage since the last transfer or load
	assign rx_all_read    = all_done({2'b00, rx_mask_r}, {2'b00, rx_evt.read},
		{2'b00, rx_en});
	assign tx_all_written = all_done(tx_mask_r, tx_evt.write, tx_en);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_mask_r <= '0;
		end else if (clear_all | rx_evt.xfer | rx_all_read) begin
			rx_mask_r <= '0;
		end else begin
			rx_mask_r <= rx_mask_r | (rx_evt.read & rx_en);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_mask_r <= '0;
		end else if (clear_all | tx_evt.load | tx_all_written | tx_evt.null_wr) begin
			tx_mask_r <= '0;
		end else begin
			tx_mask_r <= tx_mask_r | (tx_evt.write & tx_en);
		end
	end

	// Pin level caught at first data bit after frame sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_smp_r <= '0;
		end else if (rx_evt.first_bit) begin
			pin_smp_r <= pin_lvl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.in_flag <= '0;
		end else if (clear_all) begin
			st_r.in_flag <= '0;
		end else if (rx_evt.xfer) begin
			st_r.in_flag <= pin_smp_r & flag_en;
		end
	end

	// Receive full group; transfer beats a same-cycle clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.receive_full_flag  <= 1'b0;
			st_r.receive_even_full_flag <= 1'b0;
			st_r.receive_odd_full_flag <= 1'b0;
			st_r.receive_frame_start_flag  <= 1'b0;
		end else if (clear_all) begin
			st_r.receive_full_flag  <= 1'b0;
			st_r.receive_even_full_flag <= 1'b0;
			st_r.receive_odd_full_flag <= 1'b0;
			st_r.receive_frame_start_flag  <= 1'b0;
		end else if (rx_evt.xfer && rx_en != 4'h0) begin
			st_r.receive_full_flag  <= 1'b1;
			st_r.receive_even_full_flag <= net & ~rx_evt.odd_slot;
			st_r.receive_odd_full_flag <= net & rx_evt.odd_slot;
			// Normal mode has only the frame sync slot
			st_r.receive_frame_start_flag  <= ~net | rx_evt.fs_seen;
		end else if (rx_all_read) begin
			st_r.receive_full_flag  <= 1'b0;
			st_r.receive_even_full_flag <= 1'b0;
			st_r.receive_odd_full_flag <= 1'b0;
		end
	end

	// Overrun clears only after status read then all enabled reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.receive_overrun_flag  <= 1'b0;
			roe_arm_r <= 1'b0;
		end else if (clear_all) begin
			st_r.receive_overrun_flag  <= 1'b0;
			roe_arm_r <= 1'b0;
		end else if (rx_evt.xfer && rx_en != 4'h0 && st_r.receive_full_flag) begin
			st_r.receive_overrun_flag  <= 1'b1;
			roe_arm_r <= 1'b0;
		end else if (roe_arm_r & rx_all_read) begin
			st_r.receive_overrun_flag  <= 1'b0;
			roe_arm_r <= 1'b0;
		end else if (st_read & prdata[B_ROE]) begin
			roe_arm_r <= 1'b1;
		end
	end

	// Transmit frame start follows slot position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.transmit_frame_start_flag <= 1'b0;
		end else if (clear_all) begin
			st_r.transmit_frame_start_flag <= 1'b0;
		end else if (tx_evt.slot_start && tx_en != 6'h00) begin
			st_r.transmit_frame_start_flag <= ~net | tx_evt.first_slot;
		end
	end

	// Unwritten enabled transmitters at an active slot
	assign tx_short = ((tx_mask_r | tx_evt.write) & tx_en) != tx_en;
	assign tx_resend = tx_evt.slot_start & tx_evt.slot_on & ~tx_pending_r
		& tx_short & (tx_en != 6'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.transmit_underrun_flag  <= 1'b0;
			tue_arm_r <= 1'b0;
		end else if (clear_all) begin
			st_r.transmit_underrun_flag  <= 1'b0;
			tue_arm_r <= 1'b0;
		end else if (tx_resend) begin
			st_r.transmit_underrun_flag  <= 1'b1;
			tue_arm_r <= 1'b0;
		end else if (tue_arm_r & (tx_all_written | tx_evt.null_wr)) begin
			st_r.transmit_underrun_flag  <= 1'b0;
			tue_arm_r <= 1'b0;
		end else if (st_read & prdata[B_TUE]) begin
			tue_arm_r <= 1'b1;
		end
	end

	// Null slot counts as a complete write set; a load sets empty only in an active slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.transmit_empty_flag <= 1'b0;
		end else if (clear_all) begin
			st_r.transmit_empty_flag <= 1'b0;
		end else if (tx_evt.load && tx_evt.slot_on && tx_en != 6'h00) begin
			st_r.transmit_empty_flag <= 1'b1;
		end else if (tx_all_written | tx_evt.null_wr) begin
			st_r.transmit_empty_flag <= 1'b0;
		end
	end

	// Complete write set waits for the next slot's load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pending_r <= 1'b0;
		end else if (clear_all | tx_evt.load) begin
			tx_pending_r <= 1'b0;
		end else if (tx_all_written | tx_evt.null_wr) begin
			tx_pending_r <= 1'b1;
		end
	end

	// The receive exception request masks the plain receive requests
	assign irq_rx_exc  = st_r.receive_overrun_flag & ctrl_r[C_RX_EXCEPTION_IRQ_ENABLE];
	assign irq_rx      = st_r.receive_full_flag & ctrl_r[C_RIE] & ~irq_rx_exc;
	assign irq_rx_even = st_r.receive_even_full_flag & ctrl_r[C_RX_EVEN_IRQ_ENABLE] & ~irq_rx_exc;
	assign irq_tx      = st_r.transmit_empty_flag & ctrl_r[C_TIE];
	assign irq_tx_exc  = st_r.transmit_underrun_flag & ctrl_r[C_TX_EXCEPTION_IRQ_ENABLE];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	reserved_zero_a: assert property (
		psel & ~penable & ~pwrite & hit_status |=> (prdata & ~{8'h00, STATUS_USED}) == 0
	) else $error("reserved status bit read nonzero");

	flag_zero_gate_a: assert property (
		!flag_en[0] |-> !status_word[0]
	) else $error("flag zero visible while disabled");

	flag_one_gate_a: assert property (
		ctrl_r[C_TX_BUFFER_ENABLE_SELECT] |-> !status_word[1]
	) else $error("flag one visible with buffer select");

	full_set_a: assert property (
		rx_evt.xfer && rx_en != 4'h0 && !clear_all |=> st_r.receive_full_flag && status_word[B_RDF]
	) else $error("full flag not set on transfer");

	overrun_set_a: assert property (
		rx_evt.xfer && rx_en != 4'h0 && st_r.receive_full_flag && !clear_all |=> st_r.receive_overrun_flag
	) else $error("overrun not flagged");

	overrun_keep_a: assert property (
		st_r.receive_overrun_flag && !roe_arm_r && !clear_all |=> st_r.receive_overrun_flag
	) else $error("overrun cleared without status read");

	even_odd_a: assert property (
		rx_evt.xfer && rx_en != 4'h0 && !clear_all && net |=>
			st_r.receive_even_full_flag != st_r.receive_odd_full_flag && st_r.receive_odd_full_flag == $past(rx_evt.odd_slot)
	) else $error("slot parity flag wrong");

	tfs_other_a: assert property (
		tx_evt.slot_start && tx_en != 6'h00 && net && !tx_evt.first_slot && !clear_all
			|=> !st_r.transmit_frame_start_flag
	) else $error("frame start held past first slot");

	underrun_set_a: assert property (
		tx_resend && !clear_all |=> st_r.transmit_underrun_flag ##0 (irq_tx_exc == ctrl_r[C_TX_EXCEPTION_IRQ_ENABLE])
	) else $error("underrun not flagged");

	empty_clear_a: assert property (
		tx_evt.null_wr && !clear_all && !tx_evt.load |=> !st_r.transmit_empty_flag
	) else $error("empty flag kept after null slot");

	all_reset_a: assert property (
		clear_all |=> status_word == 24'h00_0000 [*1] ##1 1'b1
	) else $error("status not cleared by reset");

	irq_priority_a: assert property (
		irq_rx_exc |-> !irq_rx && !irq_rx_even
	) else $error("data request beside exception");

	pin_sample_a: assert property (
		rx_evt.xfer && !clear_all
			|=> st_r.in_flag == ($past(pin_smp_r) & $past(flag_en))
	) else $error("input flag not copied on transfer");
endmodule

// >>> include/status_pkg.sv
// Shared constants and carriers for the audio serial status-flag block
package status_pkg;
	// Register indices; byte address is four times the index
	localparam logic [23:0] STATUS_IDX = 24'hff_ffb3;
	localparam logic [23:0] CTRL_IDX   = 24'h00_0010;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam int          STATUS_W   = 24;
	localparam int          RX_N       = 4;
	localparam int          TX_N       = 6;
	localparam int          PIN_N      = 3;

	// Status word bit positions
	localparam int B_IF0  = 0;
	localparam int B_RFS  = 6;
	localparam int B_ROE  = 7;
	localparam int B_RDF  = 8;
	localparam int B_RECEIVE_EVEN_FULL_FLAG = 9;
	localparam int B_RECEIVE_ODD_FULL_FLAG = 10;
	localparam int B_TFS  = 13;
	localparam int B_TUE  = 14;
	localparam int B_TDE  = 15;
	localparam logic [23:0] STATUS_USED = 24'h00_e7c7;

	// Control register field positions
	localparam int C_SYN   = 0;
	localparam int C_RX_CLOCK_DIRECTION  = 1;
	localparam int C_RX_FRAMESYNC_DIRECTION  = 2;
	localparam int C_RX_HIGHCLOCK_DIRECTION = 3;
	localparam int C_TX_BUFFER_ENABLE_SELECT  = 4;
	localparam int C_PIN   = 5;
	localparam int C_NET   = 8;
	localparam int C_RX_EXCEPTION_IRQ_ENABLE  = 9;
	localparam int C_RIE   = 10;
	localparam int C_RX_EVEN_IRQ_ENABLE = 11;
	localparam int C_TIE   = 12;
	localparam int C_TX_EXCEPTION_IRQ_ENABLE  = 13;
	localparam int C_RXEN  = 16;
	localparam int C_TXEN  = 24;

	typedef struct packed {
		logic [2:0] in_flag;
		logic       receive_frame_start_flag;
		logic       receive_overrun_flag;
		logic       receive_full_flag;
		logic       receive_even_full_flag;
		logic       receive_odd_full_flag;
		logic       transmit_frame_start_flag;
		logic       transmit_underrun_flag;
		logic       transmit_empty_flag;
	} flags_t;

	typedef struct packed {
		logic       xfer;
		logic       first_bit;
		logic       fs_seen;
		logic       odd_slot;
		logic [3:0] read;
	} rx_evt_t;

	typedef struct packed {
		logic       slot_start;
		logic       first_slot;
		logic       slot_on;
		logic       load;
		logic       null_wr;
		logic [5:0] write;
	} tx_evt_t;
endpackage

// >>> core/pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only once two stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_out <= '0;
		end else begin
			level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
		end
	end
endmodule

// >>> sim/codec_model.sv
// Far-side converter model driving the three receiver pins
`timescale 1ns/1ns
module codec_model (
	// Bench control
	input  wire logic       run,
	input  wire logic [1:0] lvl,
	// Receiver pins
	output logic      [2:0] rx_pins
);
	logic bclk;

	initial bclk = 1'b0;
	// Link clock stands still while run is low
	always #80 bclk = run ? ~bclk : 1'b0;
	// Flag levels held steady across the first data bit
	assign rx_pins = {lvl, bclk};
endmodule

// >>> sim/audio_serial_status_flags_tb.sv
// Self-checking bench for the audio serial status-flag block
`timescale 1ns/1ns
module audio_serial_status_flags_tb;
	import status_pkg::*;
	localparam logic [31:0] ST = 32'h03ff_fecc;
	localparam logic [31:0] CT = 32'h0000_0040;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, q;
	logic        pready, pslverr, e, run, rs;
	logic [1:0]  lvl;
	logic [2:0]  rx_pins, rst3;
	rx_evt_t     rx_evt;
	tx_evt_t     tx_evt;
	logic        irq_rx_exc, irq_rx, irq_rx_even, irq_tx, irq_tx_exc;
	logic        tx_resend, tx_pending_r;
	int          mismatches, cmp_count;

	audio_serial_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pins(rx_pins),
		.rx_evt(rx_evt), .tx_evt(tx_evt), .soft_reset(rst3[0]), .unit_reset(rst3[1]),
		.stop_reset(rst3[2]), .irq_rx_exc(irq_rx_exc), .irq_rx(irq_rx),
		.irq_rx_even(irq_rx_even), .irq_tx(irq_tx), .irq_tx_exc(irq_tx_exc),
		.tx_resend(tx_resend), .tx_pending_r(tx_pending_r));
	codec_model codec (.run(run), .lvl(lvl), .rx_pins(rx_pins));

	always #10 pclk = ~pclk;

	function automatic logic [31:0] bt(input int b);
		return 32'h0000_0001 << b;
	endfunction

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: word %h want %h", $time, g, x);
		end
	endtask

	task automatic chk1(input logic g, input logic x);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: bit %b want %b", $time, g, x);
		end
	endtask

	// Master waits for pready, never a fixed count
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		chk1(pready, 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic st(input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, ST, 32'h0000_0000);
		chk32(q & m, x);
	endtask

	task automatic wr_ctrl(input logic [31:0] v);
		apb(1'b1, CT, v);
	endtask

	// One-cycle event pulse, returns once the flag has landed
	task automatic ev(input logic [7:0] r, input logic [10:0] t);
		@(posedge pclk);
		rx_evt <= rx_evt_t'(r);
		tx_evt <= tx_evt_t'(t);
		#1;
		rs = tx_resend;
		@(posedge pclk);
		rx_evt <= '0;
		tx_evt <= '0;
		@(posedge pclk);
		#1;
	endtask

	task automatic rst_pulse(input logic [2:0] v);
		@(posedge pclk);
		rst3 <= v;
		@(posedge pclk);
		rst3 <= 3'h0;
		@(posedge pclk);
	endtask

	task automatic t_reg();
		st(32'hffff_ffff, 32'h0000_0000);
		apb(1'b1, ST, 32'hffff_ffff);
		chk1(e, 1'b1);
		st(32'hffff_ffff, 32'h0000_0000);
		apb(1'b0, 32'h0000_0100, 32'h0000_0000);
		chk1(e, 1'b1);
		chk32(q, 32'h0000_0000);
		apb(1'b0, CT, 32'h0000_0000);
		chk32(q, CTRL_RST);
		wr_ctrl(32'h0000_3f01);
		chk1(e, 1'b0);
		apb(1'b0, CT, 32'h0000_0000);
		chk32(q, 32'h0000_3f01);
	endtask

	task automatic t_flags();
		logic [31:0] base;
		int          k[5];
		logic [2:0]  x[5];
		base = bt(C_SYN) | 32'h0000_00e0 | bt(C_RXEN);
		k = '{C_RX_FRAMESYNC_DIRECTION, C_TX_BUFFER_ENABLE_SELECT, C_RX_HIGHCLOCK_DIRECTION, C_PIN + 1, C_SYN};
		x = '{3'b100, 3'b100, 3'b010, 3'b100, 3'b000};
		lvl <= 2'b11;
		wr_ctrl(base);
		repeat (6) @(posedge pclk);
		ev(8'h40, 11'h000);
		ev(8'ha0, 11'h000);
		st(32'h0000_01c7, 32'h0000_0146);
		foreach (k[i]) begin
			wr_ctrl(base ^ bt(k[i]));
			st(32'h0000_0007, 32'(x[i]));
		end
	endtask

	task automatic t_over();
		wr_ctrl(bt(C_RX_EXCEPTION_IRQ_ENABLE) | bt(C_RIE) | bt(C_RXEN) | bt(C_RXEN + 1));
		ev(8'ha0, 11'h000);
		chk1(irq_rx, 1'b1);
		chk1(irq_rx_exc, 1'b0);
		ev(8'ha0, 11'h000);
		chk1(irq_rx_exc, 1'b1);
		chk1(irq_rx, 1'b0);
		st(32'h0000_0180, 32'h0000_0180);
		ev(8'h01, 11'h000);
		st(32'h0000_0180, 32'h0000_0180);
		ev(8'h02, 11'h000);
		st(32'h0000_0180, 32'h0000_0000);
		chk1(irq_rx_exc, 1'b0);
	endtask

	task automatic t_net();
		wr_ctrl(bt(C_NET) | bt(C_RX_EVEN_IRQ_ENABLE) | bt(C_RXEN));
		ev(8'ha0, 11'h000);
		st(32'h0000_0640, 32'h0000_0240);
		chk1(irq_rx_even, 1'b1);
		ev(8'h01, 11'h000);
		st(32'h0000_0600, 32'h0000_0000);
		ev(8'h90, 11'h000);
		st(32'h0000_0640, 32'h0000_0400);
		chk1(irq_rx_even, 1'b0);
		ev(8'h01, 11'h000);
		st(32'h0000_0400, 32'h0000_0000);
	endtask

	task automatic t_tx();
		wr_ctrl(bt(C_NET) | bt(C_TIE) | bt(C_TX_EXCEPTION_IRQ_ENABLE) | bt(C_TXEN));
		ev(8'h00, 11'h700);
		chk1(rs, 1'b1);
		st(32'h0000_e000, 32'h0000_6000);
		chk1(irq_tx_exc, 1'b1);
		ev(8'h00, 11'h001);
		st(32'h0000_4000, 32'h0000_0000);
		chk1(tx_pending_r, 1'b1);
		ev(8'h00, 11'h180);
		st(32'h0000_8000, 32'h0000_8000);
		chk1(irq_tx, 1'b1);
		ev(8'h00, 11'h040);
		st(32'h0000_8000, 32'h0000_0000);
		ev(8'h00, 11'h500);
		st(32'h0000_2000, 32'h0000_0000);
	endtask

	// Normal mode, plus events ignored with nothing enabled
	task automatic t_norm();
		wr_ctrl(32'h0000_0000);
		ev(8'ha0, 11'h700);
		st(32'h0000_e1c0, 32'h0000_0000);
		wr_ctrl(bt(C_RXEN) | bt(C_TXEN));
		ev(8'h80, 11'h500);
		st(32'h0000_2140, 32'h0000_2140);
	endtask

	task automatic t_rst();
		for (int i = 0; i < 4; i++) begin
			wr_ctrl(bt(C_RXEN) | bt(C_TXEN));
			ev(8'ha0, 11'h700);
			if (i < 3) begin
				rst_pulse(3'(1 << i));
			end else begin
				presetn <= 1'b0;
				repeat (2) @(posedge pclk);
				presetn <= 1'b1;
			end
			st(32'hffff_ffff, 32'h0000_0000);
		end
	endtask

	initial begin
		pclk       = 1'b0;
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 32'h0000_0000;
		pwdata     = 32'h0000_0000;
		rx_evt     = '0;
		tx_evt     = '0;
		rst3       = 3'h0;
		run        = 1'b0;
		lvl        = 2'b00;
		mismatches = 0;
		cmp_count  = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reg();
		t_flags();
		rst_pulse(3'b001);
		run <= 1'b1;
		t_over();
		rst_pulse(3'b001);
		t_net();
		rst_pulse(3'b001);
		t_tx();
		rst_pulse(3'b001);
		t_norm();
		t_rst();
		end_sim();
	end

	// Run needs a few hundred cycles; this is ample
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
endmodule
